/* verilog/adctc_regs.sv */
// adctc_regs: tuning register bank of a dual-channel converter with its dc offset loop.
// assumes a synchronous register port with one-cycle strobes and samples on mclk.
`timescale 1ns/1ns
`default_nettype none

module adctc_regs
  import adctc_pkg::*;
#(
  parameter int WAKE_CNT = WAKE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic dc_loop_enable,
  input wire logic [SAMPLE_W-1:0] chan_a_sample,
  input wire logic [SAMPLE_W-1:0] chan_b_sample,
  output logic [SAMPLE_W-1:0] chan_a_code,
  output logic [SAMPLE_W-1:0] chan_b_code,
  output logic full_chip_powerdown,
  output logic wake_busy,
  output logic chan_a_fast_input_opt,
  output logic chan_b_fast_input_opt,
  output logic chan_a_slow_rate_on,
  output logic chan_b_slow_rate_on,
  output logic swing_select_active,
  output logic [5:0] perf_bits,
  output logic perf_all_set
);

  localparam int EST_W = SAMPLE_W + 1 + FRAC_W;
  localparam int WAKE_W = $clog2(WAKE_CNT + 1);

  // stored fields; reserved positions are not kept and read back zero
  logic pdn_q;
  logic b_fast_q;
  logic a_fast_q;
  logic [BIAS_W-1:0] a_bias_q;
  logic [BIAS_W-1:0] b_bias_q;
  logic hold_q;
  logic [TC_W-1:0] tc_q;
  logic perf_3_q;
  logic perf_4_q;
  logic perf_5_q;
  logic perf_6_q;
  logic perf_7_q;
  logic perf_8_q;
  logic b_slow_q;
  logic slow_gate_q;
  logic [SWING_W-1:0] swing_gate_q;
  logic a_slow_q;

  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [WAKE_W-1:0] wake_q;
  logic signed [EST_W-1:0] a_est_q;
  logic signed [EST_W-1:0] b_est_q;
  logic [SAMPLE_W-1:0] a_code_q;
  logic [SAMPLE_W-1:0] b_code_q;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
    wr_hit = reg_wr && (reg_addr == off);
  endfunction

  // first-order loop: estimate moves by error / 2^tc each cycle
  function automatic logic signed [EST_W-1:0] est_next(
    input logic [SAMPLE_W-1:0] smp,
    input logic signed [EST_W-1:0] est,
    input logic [TC_W-1:0] tc
  );
    logic signed [EST_W:0] centred;
    logic signed [EST_W:0] err;
    logic signed [EST_W:0] step;
    centred = '0;
    err = '0;
    step = '0;
    centred = (EST_W + 1)'(signed'({1'b0, smp}) - signed'({1'b0, MIDCODE})) <<< FRAC_W;
    err = centred - (EST_W + 1)'(est);
    step = err >>> tc;
    est_next = EST_W'(est + EST_W'(step));
  endfunction

  // remove estimate, add pedestal, clamp to the code range
  function automatic logic [SAMPLE_W-1:0] correct(
    input logic [SAMPLE_W-1:0] smp,
    input logic signed [EST_W-1:0] est,
    input logic [BIAS_W-1:0] bias
  );
    logic signed [SAMPLE_W+2:0] val;
    logic signed [SAMPLE_W+2:0] whole;
    val = '0;
    whole = '0;
    whole = (SAMPLE_W + 3)'(est >>> FRAC_W);
    val = signed'({3'b000, smp}) - whole + (SAMPLE_W + 3)'(signed'(bias));
    if (val < 0) begin
      correct = '0;
    end else if (val > signed'({3'b000, CODE_MAX})) begin
      correct = CODE_MAX;
    end else begin
      correct = val[SAMPLE_W-1:0];
    end
  endfunction

  // each write touches only the addressed register
  always_ff @(posedge mclk) begin
    if (srst) begin
      pdn_q <= REG_RESET[BIT_PDN];
    end else if (wr_hit(OFF_POWER)) begin
      pdn_q <= reg_wdata[BIT_PDN];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      b_fast_q <= REG_RESET[BIT_FAST];
      a_fast_q <= REG_RESET[BIT_FAST];
    end else begin
      if (wr_hit(OFF_B_FAST)) begin
        b_fast_q <= reg_wdata[BIT_FAST];
      end
      if (wr_hit(OFF_A_FAST)) begin
        a_fast_q <= reg_wdata[BIT_FAST];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      a_bias_q <= REG_RESET[BIAS_LSB +: BIAS_W];
      b_bias_q <= REG_RESET[BIAS_LSB +: BIAS_W];
    end else begin
      if (wr_hit(OFF_A_BIAS)) begin
        a_bias_q <= reg_wdata[BIAS_LSB +: BIAS_W];
      end
      if (wr_hit(OFF_B_BIAS)) begin
        b_bias_q <= reg_wdata[BIAS_LSB +: BIAS_W];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      hold_q <= REG_RESET[BIT_HOLD];
      tc_q <= REG_RESET[TC_LSB +: TC_W];
    end else if (wr_hit(OFF_DC_LOOP)) begin
      hold_q <= reg_wdata[BIT_HOLD];
      tc_q <= reg_wdata[TC_LSB +: TC_W];
    end
  end

  // reserved bits are dropped, so a careless write cannot reach the datapath
  always_ff @(posedge mclk) begin
    if (srst) begin
      perf_3_q <= REG_RESET[BIT_PERF_3];
      perf_4_q <= REG_RESET[BIT_PERF_4];
      perf_5_q <= REG_RESET[BIT_PERF_5];
      perf_6_q <= REG_RESET[BIT_PERF_6];
      perf_7_q <= REG_RESET[BIT_PERF_7];
      perf_8_q <= REG_RESET[BIT_PERF_8];
      b_slow_q <= REG_RESET[BIT_B_SLOW];
    end else begin
      if (wr_hit(OFF_PERF_A)) begin
        perf_3_q <= reg_wdata[BIT_PERF_3];
      end
      if (wr_hit(OFF_PERF_B)) begin
        perf_4_q <= reg_wdata[BIT_PERF_4];
        perf_5_q <= reg_wdata[BIT_PERF_5];
      end
      if (wr_hit(OFF_PERF_C)) begin
        perf_6_q <= reg_wdata[BIT_PERF_6];
        perf_7_q <= reg_wdata[BIT_PERF_7];
      end
      if (wr_hit(OFF_PERF_D)) begin
        perf_8_q <= reg_wdata[BIT_PERF_8];
        b_slow_q <= reg_wdata[BIT_B_SLOW];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      slow_gate_q <= REG_RESET[BIT_SLOW_GATE];
      swing_gate_q <= REG_RESET[SWING_LSB +: SWING_W];
      a_slow_q <= REG_RESET[BIT_A_SLOW];
    end else begin
      if (wr_hit(OFF_SLOW_GATE)) begin
        slow_gate_q <= reg_wdata[BIT_SLOW_GATE];
      end
      if (wr_hit(OFF_SWING_GATE)) begin
        swing_gate_q <= reg_wdata[SWING_LSB +: SWING_W];
      end
      if (wr_hit(OFF_A_SLOW)) begin
        a_slow_q <= reg_wdata[BIT_A_SLOW];
      end
    end
  end

  // readback: unmapped offsets answer zero
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      OFF_PERF_A: rdata_d[BIT_PERF_3] = perf_3_q;
      OFF_POWER: rdata_d[BIT_PDN] = pdn_q;
      OFF_B_FAST: rdata_d[BIT_FAST] = b_fast_q;
      OFF_A_FAST: rdata_d[BIT_FAST] = a_fast_q;
      OFF_A_BIAS: rdata_d[BIAS_LSB +: BIAS_W] = a_bias_q;
      OFF_B_BIAS: rdata_d[BIAS_LSB +: BIAS_W] = b_bias_q;
      OFF_DC_LOOP: begin
        rdata_d[BIT_HOLD] = hold_q;
        rdata_d[TC_LSB +: TC_W] = tc_q;
      end
      OFF_PERF_B: begin
        rdata_d[BIT_PERF_4] = perf_4_q;
        rdata_d[BIT_PERF_5] = perf_5_q;
      end
      OFF_PERF_C: begin
        rdata_d[BIT_PERF_6] = perf_6_q;
        rdata_d[BIT_PERF_7] = perf_7_q;
      end
      OFF_PERF_D: begin
        rdata_d[BIT_PERF_8] = perf_8_q;
        rdata_d[BIT_B_SLOW] = b_slow_q;
      end
      OFF_SLOW_GATE: rdata_d[BIT_SLOW_GATE] = slow_gate_q;
      OFF_SWING_GATE: rdata_d[SWING_LSB +: SWING_W] = swing_gate_q;
      OFF_A_SLOW: rdata_d[BIT_A_SLOW] = a_slow_q;
      default: rdata_d = '0;
    endcase
  end

  // data is valid only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  // recovery timer: loaded while powered down, counts out after release
  always_ff @(posedge mclk) begin
    if (srst) begin
      wake_q <= '0;
    end else if (pdn_q) begin
      wake_q <= WAKE_W'(WAKE_CNT);
    end else if (wake_q != '0) begin
      wake_q <= wake_q - 1'b1;
    end
  end

  // loop estimates; cleared when the loop is off, kept when held
  always_ff @(posedge mclk) begin
    if (srst || !dc_loop_enable || pdn_q) begin
      a_est_q <= '0;
      b_est_q <= '0;
    end else if (!hold_q) begin
      a_est_q <= est_next(chan_a_sample, a_est_q, tc_q);
      b_est_q <= est_next(chan_b_sample, b_est_q, tc_q);
    end
  end

  // output codes; buffers are dark while down or recovering
  always_ff @(posedge mclk) begin
    if (srst || pdn_q || (wake_q != '0)) begin
      a_code_q <= '0;
      b_code_q <= '0;
    end else if (dc_loop_enable) begin
      a_code_q <= correct(chan_a_sample, a_est_q, a_bias_q);
      b_code_q <= correct(chan_b_sample, b_est_q, b_bias_q);
    end else begin
      a_code_q <= chan_a_sample;
      b_code_q <= chan_b_sample;
    end
  end

  assign reg_rdata = rdata_q;
  assign chan_a_code = a_code_q;
  assign chan_b_code = b_code_q;
  assign full_chip_powerdown = pdn_q;
  assign wake_busy = pdn_q || (wake_q != '0);
  assign chan_a_fast_input_opt = a_fast_q;
  assign chan_b_fast_input_opt = b_fast_q;
  assign chan_a_slow_rate_on = slow_gate_q && a_slow_q;
  assign chan_b_slow_rate_on = slow_gate_q && b_slow_q;
  // the two forbidden codes are treated as off
  assign swing_select_active = (swing_gate_q == SWING_ON);
  assign perf_bits = {perf_8_q, perf_7_q, perf_6_q, perf_5_q, perf_4_q, perf_3_q};
  assign perf_all_set = &perf_bits;

endmodule // adctc_regs

`default_nettype wire

/* pkg/adctc_pkg.sv */
// adctc_pkg: map, field positions, reset values and timing of the converter tuning bank.
// assumes an 8-bit register port and the 20 MHz mclk of the configuration logic.
// How it works
// - global power-down stops channels, references, buffers; wakeup takes about 100 us
// - register 4ah bit 0 selects high-input-frequency mode for channel b
// - register 58h bit 0 selects high-input-frequency mode for channel a
// - register bfh bits 7:4 hold channel a signed pedestal, -8 to +7
// - register c1h bits 7:4 hold channel b signed pedestal, independent
// - enabled correction drives each output to midcode plus its pedestal
// - register cfh bit 7 freezes estimation and keeps applying last estimate
// - register cfh bits 5:2 set the correction loop time constant
// - register efh bit 4 gates both per-channel low-speed bits
// - register f2h bit 3 is channel a low-speed, needs the gate set
// - register dbh bit 0 is channel b low-speed, needs the gate set
// - register f1h bits 1:0 gate swing control; 00 off, 11 on only
// - every register resets to all zeros
package adctc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 12;
  localparam int FRAC_W = 16;

  localparam logic [7:0] OFF_PERF_A = 8'h02;
  localparam logic [7:0] OFF_POWER = 8'h45;
  localparam logic [7:0] OFF_B_FAST = 8'h4a;
  localparam logic [7:0] OFF_A_FAST = 8'h58;
  localparam logic [7:0] OFF_A_BIAS = 8'hbf;
  localparam logic [7:0] OFF_B_BIAS = 8'hc1;
  localparam logic [7:0] OFF_DC_LOOP = 8'hcf;
  localparam logic [7:0] OFF_PERF_B = 8'hd5;
  localparam logic [7:0] OFF_PERF_C = 8'hd7;
  localparam logic [7:0] OFF_PERF_D = 8'hdb;
  localparam logic [7:0] OFF_SLOW_GATE = 8'hef;
  localparam logic [7:0] OFF_SWING_GATE = 8'hf1;
  localparam logic [7:0] OFF_A_SLOW = 8'hf2;

  localparam int BIT_PDN = 2;
  localparam int BIT_FAST = 0;
  localparam int BIAS_LSB = 4;
  localparam int BIAS_W = 4;
  localparam int BIT_HOLD = 7;
  localparam int TC_LSB = 2;
  localparam int TC_W = 4;
  localparam int BIT_SLOW_GATE = 4;
  localparam int SWING_LSB = 0;
  localparam int SWING_W = 2;
  localparam int BIT_A_SLOW = 3;
  localparam int BIT_B_SLOW = 0;
  localparam int BIT_PERF_3 = 6;
  localparam int BIT_PERF_4 = 4;
  localparam int BIT_PERF_5 = 3;
  localparam int BIT_PERF_6 = 3;
  localparam int BIT_PERF_7 = 2;
  localparam int BIT_PERF_8 = 5;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] SWING_ON = 2'h3;
  localparam logic [SAMPLE_W-1:0] MIDCODE = 12'h800;
  localparam logic [SAMPLE_W-1:0] CODE_MAX = 12'hfff;

  localparam int CLK_HZ = 20_000_000;
  localparam int WAKE_US = 100;
  localparam int WAKE_CYCLES = (WAKE_US * (CLK_HZ / 1_000_000));
endpackage : adctc_pkg

/* verif/adctc_monitor.sv */
// adctc_monitor: port checks of the tuning register bank.
// assumes one mclk domain and srst synchronous active high.
`timescale 1ns/1ns
`default_nettype none
module adctc_monitor
  import adctc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [SAMPLE_W-1:0] chan_a_code,
  input wire logic [SAMPLE_W-1:0] chan_b_code,
  input wire logic full_chip_powerdown,
  input wire logic wake_busy,
  input wire logic chan_a_fast_input_opt,
  input wire logic chan_b_fast_input_opt,
  input wire logic chan_a_slow_rate_on,
  input wire logic chan_b_slow_rate_on,
  input wire logic swing_select_active,
  input wire logic [5:0] perf_bits,
  input wire logic perf_all_set
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence wr_to(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence pdn_held;
    full_chip_powerdown ##1 full_chip_powerdown;
  endsequence
  pdn_codes_zero_a: assert property (pdn_held |-> wake_busy && chan_a_code == '0
    && chan_b_code == '0) else $error("outputs live in power down");
  pdn_write_a: assert property (wr_to(OFF_POWER) |=>
    full_chip_powerdown == $past(reg_wdata[BIT_PDN])) else $error("power bit wrong");
  fast_a_a: assert property (wr_to(OFF_A_FAST) |=>
    chan_a_fast_input_opt == $past(reg_wdata[BIT_FAST])) else $error("fast a wrong");
  fast_b_a: assert property (wr_to(OFF_B_FAST) |=>
    chan_b_fast_input_opt == $past(reg_wdata[BIT_FAST])) else $error("fast b wrong");
  slow_gate_a: assert property (wr_to(OFF_SLOW_GATE) ##0 !reg_wdata[BIT_SLOW_GATE] |=>
    !chan_a_slow_rate_on && !chan_b_slow_rate_on) else $error("slow mode not gated");
  swing_gate_a: assert property (wr_to(OFF_SWING_GATE) |=>
    swing_select_active == ($past(reg_wdata[1:0]) == SWING_ON)) else $error("swing gate");
  perf_and_a: assert property (perf_all_set == &perf_bits)
    else $error("perf summary wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
endmodule // adctc_monitor
bind adctc_regs adctc_monitor adctc_monitor_i (.*);
`default_nettype wire

/* verif/adctc_host.sv */
// adctc_host: host model writing and reading the bank.
// assumes strobes taken on the rising mclk edge.
`timescale 1ns/1ns
`default_nettype none
module adctc_host
  import adctc_pkg::*;
(
  input wire logic mclk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // released data goes to its inverse, not a stale copy
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // adctc_host
`default_nettype wire

/* verif/adctc_regs_tb_top.sv */
// adctc_regs_tb_top: directed tests of the tuning bank.
// assumes adctc_host drives the register port.
`timescale 1ns/1ns
`default_nettype none
module adctc_regs_tb_top
  import adctc_pkg::*;
;
  localparam int WK = 10;
  localparam logic [7:0] OFFS [13] = '{8'h02, 8'h45, 8'h4a, 8'h58, 8'hbf, 8'hc1,
    8'hcf, 8'hd5, 8'hd7, 8'hdb, 8'hef, 8'hf1, 8'hf2};
  localparam logic [7:0] MASKS [13] = '{8'h40, 8'h04, 8'h01, 8'h01, 8'hf0, 8'hf0,
    8'hbc, 8'h18, 8'h0c, 8'h21, 8'h10, 8'h03, 8'h08};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic dc_loop_enable = 1'b0;
  logic [11:0] smp_a = '0;
  logic [11:0] smp_b = '0;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd;
  wire logic [11:0] code_a, code_b;
  wire logic [7:0] st;
  wire logic [5:0] perf;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] d;
  always #25 mclk = ~mclk;
  adctc_host adctc_host_i (.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  adctc_regs #(.WAKE_CNT(WK)) adctc_regs_i (.mclk(mclk), .srst(srst), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .dc_loop_enable(dc_loop_enable), .chan_a_sample(smp_a), .chan_b_sample(smp_b),
    .chan_a_code(code_a), .chan_b_code(code_b), .full_chip_powerdown(st[7]),
    .wake_busy(st[6]), .chan_a_fast_input_opt(st[5]), .chan_b_fast_input_opt(st[4]),
    .chan_a_slow_rate_on(st[3]), .chan_b_slow_rate_on(st[2]),
    .swing_select_active(st[1]), .perf_bits(perf), .perf_all_set(st[0]));
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      adctc_host_i.rd(OFFS[i], d);
      chk("reset", 12'(d), 12'h000);
    end
    chk("reset st", 12'(st), 12'h000);
    // all-ones writes break the reserved-zero duty on purpose
    for (int i = 0; i < 13; i++) begin
      adctc_host_i.wr(OFFS[i], 8'hff);
      adctc_host_i.rd(OFFS[i], d);
      chk("mask", 12'(d), 12'(MASKS[i]));
    end
    chk("all st", 12'(st), 12'h0ff);
    chk("perf", 12'(perf), 12'h03f);
    adctc_host_i.wr(8'h10, 8'hff);
    adctc_host_i.rd(8'h10, d);
    chk("unmapped", 12'(d), 12'h000);
    adctc_host_i.wr(OFF_SLOW_GATE, 8'h00);
    #1 chk("gate", 12'(st[3:2]), 12'h000);
    for (int i = 1; i < 3; i++) begin
      adctc_host_i.wr(OFF_SWING_GATE, 8'(i));
      #1 chk("swing", 12'(st[1]), 12'h000);
    end
    adctc_host_i.wr(OFF_PERF_C, 8'h04);
    #1 chk("perf c", 12'(perf), 12'h037);
    adctc_host_i.rd(OFF_A_SLOW, d);
    chk("kept", 12'(d), 12'h008);
    adctc_host_i.wr(OFF_POWER, 8'h00);
    repeat (WK - 3) @(posedge mclk);
    #1 chk("waking", 12'(st[7:6]), 12'h001);
    repeat (6) @(posedge mclk);
    #1 chk("awake", 12'(st[6]), 12'h000);
    @(posedge mclk);
    smp_a <= 12'h123;
    repeat (2) @(posedge mclk);
    #1 chk("loop off", code_a, 12'h123);
    adctc_host_i.wr(OFF_DC_LOOP, 8'h00);
    adctc_host_i.wr(OFF_A_BIAS, 8'h70);
    adctc_host_i.wr(OFF_B_BIAS, 8'h80);
    smp_a <= 12'h900;
    smp_b <= 12'h900;
    dc_loop_enable <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk("bias a", code_a, 12'h807);
    chk("bias b", code_b, 12'h7f8);
    adctc_host_i.wr(OFF_DC_LOOP, 8'h80);
    smp_a <= 12'h920;
    repeat (3) @(posedge mclk);
    #1 chk("hold", code_a, 12'h827);
    conclude();
  end
endmodule // adctc_regs_tb_top
`default_nettype wire
